// ===== src/avpa_attack_timer.sv
// Purpose: attack step timer, (2n+1)*32 sample periods times 2^mult
// Assumes: sample_tick one cycle per sample period
// Notes: restart reloads the count
`timescale 1ns/100ps
`include "avpa_cfg.svh"
module avpa_attack_timer (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic sample_tick,
	input wire logic restart,
	input wire logic [4:0] base_code,
	input wire logic [2:0] mult_code,
	output logic expire
);
	logic [19:0] cnt_r;
	logic [19:0] period;

	always_comb begin
		period = 20'(((32'(base_code) * 2 + 1) * `AVPA_ATCK_UNIT) << mult_code);
	end

	always_ff @(posedge ref_clk) begin
		if (reset || restart) begin
			cnt_r <= 20'h0_0000;
		end else if (sample_tick) begin
			cnt_r <= (cnt_r + 20'h0_0001 >= period) ? 20'h0_0000 : cnt_r + 20'h0_0001;
		end
	end

	assign expire = sample_tick && (cnt_r + 20'h0_0001 >= period);
endmodule

// ===== src/avpa_bank.sv
// Purpose: right volume, phase compensation and left agc settings with their datapath
// Assumes: byte register port, read data one cycle after read strobe
// Notes: sample_tick marks each sample period; mod_tick each modulator clock cycle
`timescale 1ns/100ps
`include "avpa_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Function
// - right volume is signed seven bits, half dB, -12 to +20 dB
// - right volume resets to zero, meaning 0 dB
// - reserved bits read zero, are read-only; software writes reset value
// - phase field signed, shifts left vs right by -128..127 modulator cycles; code delays left for positive values only, negative shifts nothing
// - left agc runs only when enable bit set; resets disabled
// - target code maps to -5.5 down to -24 dB
// - hysteresis 1, 2, 4 dB for codes 0..2, none for code 3
// - noise threshold zero disables detection; else -30 to -90 dB by 2
// - clip stepping only when its bit is one; resets off
// - agc gain capped at maximum gain, half dB, 0 to 40 dB
// - maximum gain resets to all ones though reserved
// - attack base time is (2n+1)*32 sample periods
// - attack time multiplied by two to the multiplier code
module avpa_bank
	import avpa_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic mod_tick,
	input wire logic sample_tick,
	input wire logic signed [15:0] left_in,
	input wire logic signed [15:0] right_in,
	input wire logic signed [15:0] left_level_db,
	output logic signed [15:0] left_out,
	output logic signed [15:0] right_out,
	output logic [7:0] agc_gain,
	output logic agc_active,
	output logic noise_detect,
	output logic clip_step
);
	//////////////////////////////////////////////////////////////////////////////
	// registers
	logic [6:0] rvol_r;
	logic [7:0] phase_r;
	logic agc_en_r;
	logic [2:0] target_r;
	logic [1:0] hyst_r;
	logic [4:0] noise_r;
	logic clip_en_r;
	logic [6:0] gmax_r;
	logic [4:0] atk_base_r;
	logic [2:0] atk_mult_r;
	logic [7:0] rdata_nxt;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rvol_r <= `AVPA_RST_RVOL;
		end else if (reg_wr && reg_addr == `AVPA_OFS_RVOL) begin
			rvol_r <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase_r <= `AVPA_RST_PHASE;
		end else if (reg_wr && reg_addr == `AVPA_OFS_PHASE) begin
			phase_r <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			agc_en_r <= 1'b0;
			target_r <= 3'h0;
		end else if (reg_wr && reg_addr == `AVPA_OFS_AGC1) begin
			agc_en_r <= reg_wdata[`AVPA_AGC_EN_BIT];
			target_r <= reg_wdata[6:4];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hyst_r <= 2'h0;
			noise_r <= 5'h00;
			clip_en_r <= 1'b0;
		end else if (reg_wr && reg_addr == `AVPA_OFS_AGC2) begin
			hyst_r <= reg_wdata[7:6];
			noise_r <= reg_wdata[5:1];
			clip_en_r <= reg_wdata[`AVPA_CLIP_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			gmax_r <= `AVPA_RST_GMAX;
		end else if (reg_wr && reg_addr == `AVPA_OFS_GMAX) begin
			gmax_r <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			atk_base_r <= 5'h00;
			atk_mult_r <= 3'h0;
		end else if (reg_wr && reg_addr == `AVPA_OFS_ATCK) begin
			atk_base_r <= reg_wdata[7:3];
			atk_mult_r <= reg_wdata[2:0];
		end
	end

	always_comb begin
		case (reg_addr)
			`AVPA_OFS_RVOL: rdata_nxt = {1'b0, rvol_r};
			`AVPA_OFS_PHASE: rdata_nxt = phase_r;
			`AVPA_OFS_AGC1: rdata_nxt = {agc_en_r, target_r, 4'h0};
			`AVPA_OFS_AGC2: rdata_nxt = {hyst_r, noise_r, clip_en_r};
			`AVPA_OFS_GMAX: rdata_nxt = {1'b0, gmax_r};
			`AVPA_OFS_ATCK: rdata_nxt = {atk_base_r, atk_mult_r};
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// helpers

	// scale by half-dB gain: coarse 6 dB shift plus 0.5 dB table
	function automatic logic signed [15:0] apply_gain(input logic signed [15:0] x,
		input avpa_hdb_t g);
		logic signed [31:0] p;
		logic signed [7:0] q;
		logic [3:0] r;
		logic [15:0] m;
		q = g >>> 1;
		q = (g < 0) ? -((-g + 8'sd11) / 8'sd12) : g / 8'sd12;
		r = 4'(g - q * 8'sd12);
		case (r)
			4'd0: m = 16'h4000;
			4'd1: m = 16'h43c7;
			4'd2: m = 16'h47c6;
			4'd3: m = 16'h4c01;
			4'd4: m = 16'h507d;
			4'd5: m = 16'h553c;
			4'd6: m = 16'h5a82;
			4'd7: m = 16'h5fc2;
			4'd8: m = 16'h6598;
			4'd9: m = 16'h6bb4;
			4'd10: m = 16'h7231;
			default: m = 16'h7929;
		endcase
		p = (32'(x) * $signed({16'h0000, m})) >>> 14;
		p = (q < 0) ? (p >>> (-q)) : (p <<< q);
		if (p > 32'sd32767) begin
			apply_gain = 16'sh7fff;
		end else if (p < -32'sd32768) begin
			apply_gain = 16'sh8000;
		end else begin
			apply_gain = p[15:0];
		end
	endfunction

	function automatic avpa_hdb_t target_hdb(input logic [2:0] c);
		case (c)
			3'd0: target_hdb = -8'sd11;
			3'd1: target_hdb = -8'sd16;
			3'd2: target_hdb = -8'sd20;
			3'd3: target_hdb = -8'sd24;
			3'd4: target_hdb = -8'sd28;
			3'd5: target_hdb = -8'sd34;
			3'd6: target_hdb = -8'sd40;
			default: target_hdb = -8'sd48;
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// right channel volume
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			right_out <= 16'sh0000;
		end else if (sample_tick) begin
			right_out <= apply_gain(right_in, avpa_hdb_t'($signed(rvol_r)));
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// phase compensation: delay the left channel by phase modulator cycles; a negative phase delays neither channel
	logic [7:0] wp_r;
	logic [7:0] shift_amt;
	logic [15:0] dly_data;
	logic neg_shift;
	logic signed [15:0] dly_in;

	assign neg_shift = phase_r[7];
	assign shift_amt = neg_shift ? 8'(-phase_r) : phase_r;
	assign dly_in = neg_shift ? right_in : left_in;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wp_r <= 8'h00;
		end else if (mod_tick) begin
			wp_r <= wp_r + 8'h01;
		end
	end

	avpa_delay_mem u_dly (
		.ref_clk(ref_clk),
		.wr_addr(wp_r),
		.wr_data(dly_in),
		.wr_en(mod_tick),
		.rd_addr(8'(wp_r - shift_amt)),
		.rd_data(dly_data)
	);

	//////////////////////////////////////////////////////////////////////////////
	// left agc
	avpa_state_t st_r;
	avpa_hdb_t gain_r;
	logic atk_exp;
	logic signed [15:0] left_aligned;
	logic signed [15:0] err;
	logic signed [15:0] hyst;
	logic noisy;

	assign left_aligned = (phase_r == 8'h00 || neg_shift) ? left_in : $signed(dly_data);

	avpa_attack_timer u_atk (
		.ref_clk(ref_clk),
		.reset(reset),
		.sample_tick(sample_tick),
		.restart(!agc_en_r),
		.base_code(atk_base_r),
		.mult_code(atk_mult_r),
		.expire(atk_exp)
	);

	always_comb begin
		case (hyst_r)
			2'd0: hyst = 16'sd2;
			2'd1: hyst = 16'sd4;
			2'd2: hyst = 16'sd8;
			default: hyst = 16'sd0;
		endcase
	end

	assign err = 16'(16'(target_hdb(target_r)) - left_level_db - 16'(gain_r));

	assign noisy = (noise_r != 5'h00) &&
		(left_level_db < -16'(2 * (`AVPA_NOISE_TOP_DB + `AVPA_NOISE_STEP_DB *
		(32'(noise_r) - 1))));

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_r <= AVPA_IDLE;
			gain_r <= 8'sh00;
		end else begin
			case (st_r)
				AVPA_IDLE: begin
					if (agc_en_r) begin
						st_r <= AVPA_WAIT;
					end
				end
				AVPA_WAIT: begin
					if (!agc_en_r) begin
						st_r <= AVPA_IDLE;
					end else if (atk_exp) begin
						st_r <= AVPA_STEP;
					end
				end
				AVPA_STEP: begin
					st_r <= AVPA_WAIT;
					if (!noisy && err > hyst) begin
						gain_r <= gain_r + 8'sh01;
					end else if (err < -hyst || (clip_en_r && err < 0)) begin
						gain_r <= (gain_r > 8'sh00) ? gain_r - 8'sh01 : 8'sh00;
					end
					if (gain_r >= $signed({1'b0, gmax_r})) begin
						gain_r <= $signed({1'b0, gmax_r});
					end
				end
				default: st_r <= AVPA_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			left_out <= 16'sh0000;
			clip_step <= 1'b0;
		end else if (sample_tick) begin
			left_out <= apply_gain(left_aligned, agc_en_r ? gain_r : 8'sh00);
			clip_step <= agc_en_r && clip_en_r && (left_level_db > 16'sh0000);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			agc_gain <= 8'h00;
			agc_active <= 1'b0;
			noise_detect <= 1'b0;
		end else begin
			agc_gain <= gain_r;
			agc_active <= agc_en_r;
			noise_detect <= agc_en_r && noisy;
		end
	end
endmodule

// ===== src/avpa_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the volume/phase/agc bank
// Assumes: byte-wide register port, one register per offset
// Notes: included by the bank and attack timer design files
`ifndef AVPA_CFG_SVH
`define AVPA_CFG_SVH
`define AVPA_OFS_RVOL 8'h54
`define AVPA_OFS_PHASE 8'h55
`define AVPA_OFS_AGC1 8'h56
`define AVPA_OFS_AGC2 8'h57
`define AVPA_OFS_GMAX 8'h58
`define AVPA_OFS_ATCK 8'h59
`define AVPA_RST_RVOL 7'h00
`define AVPA_RST_PHASE 8'h00
`define AVPA_RST_GMAX 7'h7f
`define AVPA_AGC_EN_BIT 7
`define AVPA_CLIP_BIT 0
`define AVPA_RVOL_MAX 7'sh28
`define AVPA_GMAX_LEGAL 7'h50
`define AVPA_ATCK_UNIT 32
`define AVPA_NOISE_TOP_DB 30
`define AVPA_NOISE_STEP_DB 2
`endif

// ===== src/avpa_delay_mem.sv
// Purpose: 256-word sample delay line for the left-channel phase shift
// Assumes: one write and one read per clock
// Notes: read data registered
`timescale 1ns/100ps
module avpa_delay_mem (
	input wire logic ref_clk,
	input wire logic [7:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic wr_en,
	input wire logic [7:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem [0:255];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== src/avpa_pkg.sv
// Purpose: types shared by the volume/phase/agc bank
// Assumes: gains in half-decibel units
// Notes: none
package avpa_pkg;
	typedef logic signed [7:0] avpa_hdb_t;
	typedef enum logic [1:0] {
		AVPA_IDLE = 2'b00,
		AVPA_WAIT = 2'b01,
		AVPA_STEP = 2'b10
	} avpa_state_t;
endpackage

// ===== verif/avpa_bank_checker.sv
// Purpose: port checks of avpa_bank
// Assumes: one clock, sync reset
// Notes: bound after endmodule
`timescale 1ns/100ps
module avpa_bank_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] agc_gain,
	input wire logic agc_active,
	input wire logic noise_detect,
	input wire logic clip_step
);
	logic [6:0] gmax_r;
	logic [4:0] thr_r;
	logic clip_r;
	wire en_wr = reg_wr && reg_addr == 8'h56 && reg_wdata[7];
	//////////////////////////////////////////////////////////////////////////////
	// shadow of the fields the checks need
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			gmax_r <= 7'h7f;
			thr_r <= 5'h00;
			clip_r <= 1'b0;
		end else if (reg_wr && reg_addr == 8'h58) begin
			gmax_r <= reg_wdata[6:0];
		end else if (reg_wr && reg_addr == 8'h57) begin
			thr_r <= reg_wdata[5:1];
			clip_r <= reg_wdata[0];
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside read slot");
	a_rvol_rsv_bit: assert property ($past(reg_rd) && $past(reg_addr) == 8'h54 |-> !reg_rdata[7])
		else $error("right volume reserved bit set");
	a_agc1_rsv_bits: assert property ($past(reg_rd) && $past(reg_addr) == 8'h56
		|-> reg_rdata[3:0] == 4'h0)
		else $error("agc control reserved bits set");
	a_gmax_rsv_bit: assert property ($past(reg_rd) && $past(reg_addr) == 8'h58 |-> !reg_rdata[7])
		else $error("max gain reserved bit set");
	a_enable_cause: assert property ($rose(agc_active) |-> $past(en_wr) || $past(en_wr, 2))
		else $error("agc active without enable write");
	a_gain_unit_step: assert property (agc_active && $past(agc_active)
		&& agc_gain != $past(agc_gain)
		|-> agc_gain == $past(agc_gain) + 8'h01 || agc_gain == $past(agc_gain) - 8'h01)
		else $error("agc gain moved more than one step");
	a_gain_ceiling: assert property (agc_active && agc_gain > $past(agc_gain)
		|-> agc_gain <= {1'b0, $past(gmax_r)})
		else $error("agc gain above maximum");
	a_noise_off: assert property (thr_r == 5'h00 && $past(thr_r) == 5'h00
		&& $past(thr_r, 2) == 5'h00 |-> !noise_detect)
		else $error("noise detect with zero threshold");
	a_clip_cause: assert property ($rose(clip_step) |-> $past(clip_r))
		else $error("clip step while disabled");
	c_read_gmax: cover property ($past(reg_rd) && $past(reg_addr) == 8'h58);
	c_gain_move: cover property (agc_active && agc_gain != $past(agc_gain));
	c_noise: cover property ($rose(noise_detect));
endmodule
bind avpa_bank avpa_bank_checker chk (.*);

// ===== verif/avpa_bank_tb.sv
// Purpose: self-checking bench of avpa_bank
// Assumes: read data one cycle after strobe
// Notes: expected reads and samples queued, monitor pops
`timescale 1ns/100ps
module avpa_bank_tb;
	logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, mod_tick = 0, sample_tick = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, agc_gain, d;
	logic agc_active, noise_detect, clip_step, rd_p, tk_p;
	logic signed [15:0] left_in = 0, right_in = 0, left_level_db = 0, left_out, right_out, l, r;
	logic [15:0] exp_q[$];
	int error_cnt = 0, tests_run = 0, seed = 9512, i, j;
	logic [7:0] adr[7] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a};
	logic [7:0] rst[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00};
	logic [7:0] msk[7] = '{8'h7f, 8'hff, 8'hf0, 8'hff, 8'h7f, 8'hff, 8'h00};
	logic [6:0] vc[3] = '{7'h00, 7'h0c, 7'h74};
	logic [7:0] nz[3] = '{8'h00, 8'h02, 8'h3e};
	logic nx[3] = '{1'b0, 1'b1, 1'b0};
	always #4 ref_clk = ~ref_clk;
	avpa_bank uut (.*);
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({8'h00, e});
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge ref_clk);
	endtask
	task automatic idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		sample_tick <= 1'b0;
		mod_tick <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			sample_tick <= 1'b1;
			@(posedge ref_clk);
		end
	endtask
	//////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		rd_p <= reg_rd;
		tk_p <= sample_tick;
	end
	always @(negedge ref_clk) begin
		if (rd_p === 1'b1) chk({8'h00, reg_rdata}, exp_q.pop_front());
		else if (tk_p === 1'b1 && exp_q.size() > 1) begin
			chk(left_out, exp_q.pop_front());
			chk(right_out, exp_q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		for (i = 0; i < 7; i++) rd(adr[i], rst[i]);
		$display("test reset values done");
		for (i = 0; i < 7; i++) wr(adr[i], msk[i]);
		for (i = 0; i < 7; i++) rd(adr[i], msk[i]);
		for (i = 0; i < 12; i++) begin
			d = 8'($random(seed));
			wr(adr[1 + 2 * (i % 3)], d);
			rd(adr[1 + 2 * (i % 3)], d);
		end
		wr(8'h54, 8'h68);
		rd(8'h54, 8'h68);
		wr(8'h54, 8'h28);
		rd(8'h54, 8'h28);
		wr(8'h58, 8'h50);
		rd(8'h58, 8'h50);
		$display("test register access done");
		wr(8'h55, 8'h00);
		wr(8'h56, 8'h00);
		for (i = 0; i < 3; i++) begin
			wr(8'h54, {1'b0, vc[i]});
			idle();
			for (j = 0; j < 4; j++) begin
				l = 16'(($random(seed) % 1024) * 4);
				r = 16'(($random(seed) % 1024) * 4);
				exp_q.push_back(l);
				exp_q.push_back(i == 0 ? r : i == 1 ? r * 2 : r >>> 1);
				left_in <= l;
				right_in <= r;
				sample_tick <= 1'b1;
				mod_tick <= 1'b1;
				@(posedge ref_clk);
			end
			idle();
		end
		$display("test datapath done");
		left_level_db <= -16'sd100;
		wr(8'h58, 8'h02);
		wr(8'h59, 8'h00);
		wr(8'h57, 8'h00);
		wr(8'h56, 8'h80);
		idle();
		tick(20);
		#1 chk(agc_gain, 16'h0000);
		chk(agc_active, 1'b1);
		tick(80);
		#1 chk(agc_gain, 16'h0002);
		wr(8'h58, 8'h50);
		wr(8'h59, 8'h07);
		idle();
		tick(3000);
		#1 chk(agc_gain <= 8'h03, 1'b1);
		for (i = 0; i < 3; i++) begin
			wr(8'h57, nz[i]);
			idle();
			tick(4);
			#1 chk(noise_detect, nx[i]);
		end
		left_level_db <= 16'sd4;
		wr(8'h57, 8'h01);
		idle();
		tick(2);
		#1 chk(clip_step, 1'b1);
		wr(8'h56, 8'h00);
		idle();
		tick(3);
		#1 chk(agc_active, 1'b0);
		$display("test agc done");
		print_verdict();
	end
endmodule
